// >>> fbes_params.svh
// Purpose: Constants for the bulk erase and erase suspend controller
// Assumes: 50 MHz core clock
// Notes:   Opcodes are instruction bytes as shifted in on the link
`ifndef FBES_PARAMS_SVH
`define FBES_PARAMS_SVH
`define FBES_OP_UNLOCK     8'h06
`define FBES_OP_RD_STAT1   8'h05
`define FBES_OP_RD_STAT2   8'h07
`define FBES_OP_BULK_A     8'h60
`define FBES_OP_BULK_B     8'hC7
`define FBES_OP_SEC_ERS    8'hD8
`define FBES_OP_SEC_ERS4   8'hDC
`define FBES_OP_ERS_PAUSE  8'h75
`define FBES_OP_ERS_CONT   8'h7A
`define FBES_OP_PRG_PAUSE  8'h85
`define FBES_OP_PRG_CONT   8'h8A
`define FBES_OP_PAGE_WR    8'h02
`define FBES_OP_PAGE_WR4   8'h12
`define FBES_OP_STAT_WR    8'h01
`define FBES_OP_BANK_ACC   8'hB9
`define FBES_OP_BANK_RD    8'h16
`define FBES_OP_BANK_WR    8'h17
`define FBES_OP_CLR_STAT   8'h30
`define FBES_OP_VLOCK_RD   8'hE0
`define FBES_OP_VLOCK_WR   8'hE1
`define FBES_OP_MODE_RST   8'hFF
`define FBES_OP_QREAD      8'h0B
`define FBES_OP_QREAD4     8'h0C
`define FBES_S1_BUSY       0
`define FBES_S1_LATCH      1
`define FBES_S2_PSUSP      0
`define FBES_S2_ESUSP      1
`define FBES_SECTOR_LSB    20
`define FBES_SECTORS       16
`define FBES_VLOCK_ON      8'h00
`define FBES_LEN_CMD       6'h08
`define FBES_LEN_DATA      6'h10
`define FBES_LEN_ADDR3     6'h20
`define FBES_LEN_ADDR4     6'h28
`define FBES_LEN_MAX       6'h30
`define FBES_CLK_MHZ       50
`define FBES_SUSP_LAT_NS   45000
`define FBES_BULK_CYC      32'h000F4240
`define FBES_SECT_CYC      32'h000186A0
`define FBES_PROG_CYC      32'h00000FA0
`endif

// >>> fbes_pkg.sv
// Purpose: Types shared by the controller and its link front end
// Assumes: fbes_params.svh supplies the sector count
// Notes:   None
`include "fbes_params.svh"
package fbes_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BULK,
        ST_SECTOR,
        ST_SUSPENDING,
        ST_ERS_SUSP,
        ST_PROG,
        ST_PROG_SUSP
    } fbes_state_t;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [39:0] arg;
        logic [5:0]  count;
        logic        differ;
    } fbes_link_t;

    typedef struct packed {
        fbes_state_t               state;
        logic [31:0]               work_cnt;
        logic [31:0]               lat_cnt;
        logic [31:0]               prog_cnt;
        logic                      latch;
        logic [2:0]                guard;
        logic                      erase_err;
        logic                      prog_err;
        logic                      nested;
        logic [3:0]                erase_sector;
        logic [3:0]                prog_sector;
        logic [7:0]                bank;
        logic                      bank_armed;
        logic [`FBES_SECTORS-1:0]  vlock;
        logic [`FBES_SECTORS-1:0]  erased;
        logic [7:0]                status_one;
        logic [7:0]                status_two;
        logic [3:0]                read_sector;
        logic                      read_done;
        logic                      read_erased;
        logic                      read_undefined;
        logic                      cs_meta;
        logic                      cs_sync;
        logic                      cs_prev;
    } fbes_core_t;
endpackage

// >>> fbes_link.sv
// Purpose: Link front end, captures one frame on the serial clock
// Assumes: Serial clock stops while chip select is high
// Notes:   Frame contents stay still after chip select rises
`timescale 1ns/1ns
`include "fbes_params.svh"
module fbes_link (
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        lane_low_bit0,
    input  wire logic        lane_high_bit0,
    output logic [7:0]       opcode,
    output logic [39:0]      arg,
    output logic [5:0]       bit_count,
    output logic             lanes_differ
);
    fbes_pkg::fbes_link_t r_reg;
    fbes_pkg::fbes_link_t r_next;
    logic                 fresh_reg;
    logic [5:0]           idx;

    // Chip select high marks the next edge as the first bit of a frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    always_comb begin
        r_next = r_reg;
        idx = `FBES_LEN_MAX - 6'h01 - r_reg.count;
        if (fresh_reg) begin
            r_next.opcode = {7'h00, lane_low_bit0};
            r_next.arg = '0;
            r_next.count = 6'h01;
            r_next.differ = lane_low_bit0 ^ lane_high_bit0;
        end else begin
            if (r_reg.count < `FBES_LEN_CMD) begin
                r_next.opcode = {r_reg.opcode[6:0], lane_low_bit0};
                r_next.differ = r_reg.differ | (lane_low_bit0 ^ lane_high_bit0);
            end else if (r_reg.count < `FBES_LEN_MAX) begin
                r_next.arg[idx] = lane_low_bit0;
            end
            if (r_reg.count != 6'h3F) begin
                r_next.count = r_reg.count + 6'h01;
            end
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign opcode = r_reg.opcode;
    assign arg = r_reg.arg;
    assign bit_count = r_reg.count;
    assign lanes_differ = r_reg.differ;
endmodule

// >>> fbes_ctrl.sv
// Purpose: Bulk erase and erase suspend sequencing for a serial NOR die
// Assumes: Host shifts the same instruction on both lane groups
// Notes:   Array contents are tracked per sector as erased or written
// Summary of operation
// - Bulk erase, either opcode, erases all unlocked sectors
// - Bulk erase needs write latch set first
// - Chip select rise right after eighth bit
// - Erase starts at chip select rise; busy shown
// - Nonzero guard bits silently ignore bulk erase
// - Bulk erase skips locked sectors, no error
// - Erase pause only during sector erase
// - Suspend takes effect within bounded latency
// - Only status reads while suspend settles
// - Busy clears; status two shows suspended
// - Erase continue ignored unless erase suspended
// - Valid continue sets busy, resumes erase
// - Reads in suspended sector are undefined
// - Unlock needed before nonvolatile changes, always
// - Status write rejected in suspend, bank exception
// - Program into suspended sector fails, flag set
// - Nested program returns to erase suspend
// - Erase-suspend-only command set accepted
// - Page program and program pause in suspend
// - Bank, mode reset, fast reads in both
// - Program continue resumes nested program
`timescale 1ns/1ns
`include "fbes_params.svh"
module fbes_ctrl #(
    parameter logic [31:0] BULK_ERASE_CYCLES  = `FBES_BULK_CYC,
    parameter logic [31:0] SECTOR_ERASE_CYCLES = `FBES_SECT_CYC,
    parameter logic [31:0] PROGRAM_CYCLES     = `FBES_PROG_CYC,
    parameter logic [31:0] SUSPEND_LAT_CYCLES = 32'((`FBES_SUSP_LAT_NS * `FBES_CLK_MHZ) / 1000)
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     sclk,
    input  wire logic                     cs_n,
    input  wire logic                     lane_low_bit0,
    input  wire logic                     lane_high_bit0,
    input  wire logic [`FBES_SECTORS-1:0] persistent_sector_lock,
    output logic [7:0]                    status_one,
    output logic [7:0]                    status_two,
    output logic [7:0]                    bank_reg,
    output logic [`FBES_SECTORS-1:0]      erased_map,
    output logic [3:0]                    read_sector,
    output logic                          read_done,
    output logic                          read_erased,
    output logic                          read_undefined
);
    fbes_pkg::fbes_core_t     r_reg;
    fbes_pkg::fbes_core_t     r_next;
    logic [7:0]               link_opcode;
    logic [39:0]              link_arg;
    logic [5:0]               link_count;
    logic                     link_differ;
    logic                     frame_end;
    logic                     wide;
    logic [31:0]              addr;
    logic [3:0]               sec;
    logic [7:0]               data8;
    logic [5:0]               addr_len;
    logic                     ers_susp;
    logic                     prg_susp;
    logic                     erase_held;
    logic                     allowed;
    logic [`FBES_SECTORS-1:0] locks;

    fbes_link u_link (
        .rst            (rst),
        .sclk           (sclk),
        .cs_n           (cs_n),
        .lane_low_bit0  (lane_low_bit0),
        .lane_high_bit0 (lane_high_bit0),
        .opcode         (link_opcode),
        .arg            (link_arg),
        .bit_count      (link_count),
        .lanes_differ   (link_differ)
    );

    function automatic logic is_busy(input fbes_pkg::fbes_state_t s);
        return (s == fbes_pkg::ST_BULK) || (s == fbes_pkg::ST_SECTOR) ||
               (s == fbes_pkg::ST_SUSPENDING) || (s == fbes_pkg::ST_PROG);
    endfunction

    // Commands that survive a suspend; the rest fall to default
    function automatic logic suspend_ok(input logic [7:0] op, input logic erase_susp);
        logic ok;
        ok = 1'b0;
        case (op)
            `FBES_OP_BANK_ACC, `FBES_OP_BANK_RD, `FBES_OP_BANK_WR,
            `FBES_OP_QREAD, `FBES_OP_QREAD4, `FBES_OP_MODE_RST,
            `FBES_OP_PRG_CONT, `FBES_OP_RD_STAT1, `FBES_OP_RD_STAT2: begin
                ok = 1'b1;
            end
            `FBES_OP_CLR_STAT, `FBES_OP_VLOCK_RD, `FBES_OP_VLOCK_WR,
            `FBES_OP_ERS_CONT, `FBES_OP_PRG_PAUSE, `FBES_OP_PAGE_WR,
            `FBES_OP_PAGE_WR4, `FBES_OP_UNLOCK: begin
                ok = erase_susp;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // Short addresses take their top byte from the bank register
    function automatic logic [31:0] addr_of(input logic [39:0] a, input logic w, input logic [7:0] b);
        return w ? a[39:8] : {b, a[39:16]};
    endfunction

    always_comb begin
        r_next = r_reg;
        r_next.cs_meta = cs_n;
        r_next.cs_sync = r_reg.cs_meta;
        r_next.cs_prev = r_reg.cs_sync;
        r_next.read_done = 1'b0;
        frame_end = r_reg.cs_sync & ~r_reg.cs_prev;
        wide = (link_opcode == `FBES_OP_SEC_ERS4) || (link_opcode == `FBES_OP_PAGE_WR4) ||
               (link_opcode == `FBES_OP_QREAD4);
        addr = addr_of(link_arg, wide, r_reg.bank);
        sec = addr[`FBES_SECTOR_LSB +: 4];
        addr_len = wide ? `FBES_LEN_ADDR4 : `FBES_LEN_ADDR3;
        data8 = wide ? link_arg[7:0] : link_arg[15:8];
        locks = r_reg.vlock | persistent_sector_lock;
        ers_susp = (r_reg.state == fbes_pkg::ST_ERS_SUSP);
        prg_susp = (r_reg.state == fbes_pkg::ST_PROG_SUSP);
        erase_held = ers_susp || r_reg.nested;

        // Erase and program engines
        case (r_reg.state)
            fbes_pkg::ST_BULK: begin
                if (r_reg.work_cnt == 32'h0) begin
                    r_next.erased = r_reg.erased | ~locks;
                    r_next.state = fbes_pkg::ST_IDLE;
                end else begin
                    r_next.work_cnt = r_reg.work_cnt - 32'h1;
                end
            end
            fbes_pkg::ST_SECTOR: begin
                if (r_reg.work_cnt == 32'h0) begin
                    r_next.erased[r_reg.erase_sector] = 1'b1;
                    r_next.state = fbes_pkg::ST_IDLE;
                end else begin
                    r_next.work_cnt = r_reg.work_cnt - 32'h1;
                end
            end
            fbes_pkg::ST_SUSPENDING: begin
                // Erase keeps running until the latency expires
                if (r_reg.work_cnt == 32'h0) begin
                    r_next.erased[r_reg.erase_sector] = 1'b1;
                    r_next.state = fbes_pkg::ST_IDLE;
                end else if (r_reg.lat_cnt == 32'h0) begin
                    r_next.state = fbes_pkg::ST_ERS_SUSP;
                end else begin
                    r_next.work_cnt = r_reg.work_cnt - 32'h1;
                    r_next.lat_cnt = r_reg.lat_cnt - 32'h1;
                end
            end
            fbes_pkg::ST_PROG: begin
                if (r_reg.prog_cnt == 32'h0) begin
                    r_next.erased[r_reg.prog_sector] = 1'b0;
                    r_next.nested = 1'b0;
                    if (r_reg.nested) begin
                        r_next.state = fbes_pkg::ST_ERS_SUSP;
                    end else begin
                        r_next.state = fbes_pkg::ST_IDLE;
                    end
                end else begin
                    r_next.prog_cnt = r_reg.prog_cnt - 32'h1;
                end
            end
            default: begin
            end
        endcase

        // Which commands this state takes
        case (r_reg.state)
            fbes_pkg::ST_IDLE: begin
                allowed = 1'b1;
            end
            fbes_pkg::ST_ERS_SUSP, fbes_pkg::ST_PROG_SUSP: begin
                allowed = suspend_ok(link_opcode, ers_susp) ||
                          (link_opcode == `FBES_OP_STAT_WR && r_reg.bank_armed);
            end
            fbes_pkg::ST_SECTOR: begin
                allowed = (link_opcode == `FBES_OP_ERS_PAUSE);
            end
            fbes_pkg::ST_PROG: begin
                allowed = (link_opcode == `FBES_OP_PRG_PAUSE);
            end
            default: begin
                // Settling suspend and bulk erase only serve status reads
                allowed = 1'b0;
            end
        endcase

        if (frame_end && !link_differ) begin
            r_next.bank_armed = (link_opcode == `FBES_OP_BANK_ACC);
        end

        if (frame_end && !link_differ && allowed) begin
            case (link_opcode)
                `FBES_OP_UNLOCK: begin
                    if (link_count == `FBES_LEN_CMD) begin
                        r_next.latch = 1'b1;
                    end
                end
                `FBES_OP_BULK_A, `FBES_OP_BULK_B: begin
                    // Any extra bit after the opcode cancels the erase
                    if (link_count == `FBES_LEN_CMD && r_reg.latch) begin
                        r_next.latch = 1'b0;
                        if (r_reg.guard == 3'h0) begin
                            r_next.state = fbes_pkg::ST_BULK;
                            r_next.work_cnt = BULK_ERASE_CYCLES;
                        end
                    end
                end
                `FBES_OP_SEC_ERS, `FBES_OP_SEC_ERS4: begin
                    if (link_count == addr_len && r_reg.latch) begin
                        r_next.latch = 1'b0;
                        if (locks[sec]) begin
                            r_next.erase_err = 1'b1;
                        end else begin
                            r_next.state = fbes_pkg::ST_SECTOR;
                            r_next.work_cnt = SECTOR_ERASE_CYCLES;
                            r_next.erase_sector = sec;
                        end
                    end
                end
                `FBES_OP_ERS_PAUSE: begin
                    if (link_count == `FBES_LEN_CMD && r_reg.state == fbes_pkg::ST_SECTOR) begin
                        r_next.state = fbes_pkg::ST_SUSPENDING;
                        r_next.lat_cnt = SUSPEND_LAT_CYCLES;
                    end
                end
                `FBES_OP_ERS_CONT: begin
                    if (link_count == `FBES_LEN_CMD && ers_susp) begin
                        r_next.state = fbes_pkg::ST_SECTOR;
                    end
                end
                `FBES_OP_PAGE_WR, `FBES_OP_PAGE_WR4: begin
                    if (link_count >= addr_len + 6'h08 && r_reg.latch) begin
                        r_next.latch = 1'b0;
                        if ((ers_susp && sec == r_reg.erase_sector) || locks[sec]) begin
                            r_next.prog_err = 1'b1;
                        end else begin
                            r_next.state = fbes_pkg::ST_PROG;
                            r_next.prog_cnt = PROGRAM_CYCLES;
                            r_next.prog_sector = sec;
                            r_next.nested = ers_susp;
                        end
                    end
                end
                `FBES_OP_PRG_PAUSE: begin
                    if (link_count == `FBES_LEN_CMD && r_reg.state == fbes_pkg::ST_PROG) begin
                        r_next.state = fbes_pkg::ST_PROG_SUSP;
                    end
                end
                `FBES_OP_PRG_CONT: begin
                    if (link_count == `FBES_LEN_CMD && prg_susp) begin
                        r_next.state = fbes_pkg::ST_PROG;
                    end
                end
                `FBES_OP_STAT_WR: begin
                    if (link_count >= `FBES_LEN_DATA) begin
                        if (r_reg.bank_armed) begin
                            r_next.bank = link_arg[39:32];
                        end else if (r_reg.latch) begin
                            r_next.latch = 1'b0;
                            r_next.guard = link_arg[36:34];
                        end
                    end
                end
                `FBES_OP_BANK_WR: begin
                    if (link_count >= `FBES_LEN_DATA) begin
                        r_next.bank = link_arg[39:32];
                    end
                end
                `FBES_OP_CLR_STAT: begin
                    if (link_count == `FBES_LEN_CMD) begin
                        r_next.erase_err = 1'b0;
                        r_next.prog_err = 1'b0;
                    end
                end
                `FBES_OP_VLOCK_WR: begin
                    if (link_count >= addr_len + 6'h08) begin
                        r_next.vlock[sec] = (data8 == `FBES_VLOCK_ON);
                    end
                end
                `FBES_OP_QREAD, `FBES_OP_QREAD4: begin
                    if (link_count >= addr_len) begin
                        r_next.read_done = 1'b1;
                        r_next.read_sector = sec;
                        r_next.read_erased = r_reg.erased[sec];
                        r_next.read_undefined = erase_held && sec == r_reg.erase_sector;
                    end
                end
                default: begin
                end
            endcase
        end

        r_next.status_one = 8'h00;
        r_next.status_one[`FBES_S1_BUSY] = is_busy(r_next.state);
        r_next.status_one[`FBES_S1_LATCH] = r_next.latch;
        r_next.status_one[4:2] = r_next.guard;
        r_next.status_one[5] = r_next.erase_err;
        r_next.status_one[6] = r_next.prog_err;
        r_next.status_two = 8'h00;
        r_next.status_two[`FBES_S2_PSUSP] = (r_next.state == fbes_pkg::ST_PROG_SUSP);
        r_next.status_two[`FBES_S2_ESUSP] = (r_next.state == fbes_pkg::ST_ERS_SUSP) || r_next.nested;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
            // Synchroniser starts at the idle level of chip select, so no false frame end
            r_reg.cs_meta <= 1'b1;
            r_reg.cs_sync <= 1'b1;
            r_reg.cs_prev <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign status_one = r_reg.status_one;
    assign status_two = r_reg.status_two;
    assign bank_reg = r_reg.bank;
    assign erased_map = r_reg.erased;
    assign read_sector = r_reg.read_sector;
    assign read_done = r_reg.read_done;
    assign read_erased = r_reg.read_erased;
    assign read_undefined = r_reg.read_undefined;
endmodule

// >>> fbes_checker.sv
// Purpose: Port assertions for the erase controller
// Assumes: Core clock domain only
// Notes:   Attached by bind
`timescale 1ns/1ns
module fbes_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic [15:0] persistent_sector_lock,
    input wire logic [7:0]  status_one,
    input wire logic [7:0]  status_two,
    input wire logic [15:0] erased_map,
    input wire logic        read_done,
    input wire logic        read_undefined
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence busy_up; $rose(status_one[0]); endsequence
    sequence idle_start; busy_up ##0 !$past(status_two[1]); endsequence
    busy_cs_a: assert property (busy_up |-> $past(cs_n, 2)) else $error("busy rose in frame");
    unlock_first_a: assert property (idle_start |-> $past(status_one[1])) else $error("no latch");
    latch_used_a: assert property (idle_start |-> !status_one[1]) else $error("latch kept");
    suspend_idle_a: assert property ($rose(status_two[1]) |-> !status_one[0]) else $error("busy in suspend");
    resume_busy_a: assert property ($fell(status_two[1]) |-> status_one[0]) else $error("resume idle");
    read_pulse_a: assert property (read_done |=> !read_done) else $error("read pulse long");
    undef_susp_a: assert property (read_done && read_undefined |-> status_two[1]) else $error("undef");
    lock_skip_a: assert property (!(|(erased_map & ~$past(erased_map) & persistent_sector_lock)))
        else $error("locked sector erased");
endmodule
bind fbes_ctrl fbes_checker u_chk (.clk(clk), .rst(rst), .cs_n(cs_n),
    .persistent_sector_lock(persistent_sector_lock), .status_one(status_one), .status_two(status_two),
    .erased_map(erased_map), .read_done(read_done), .read_undefined(read_undefined));

// >>> fbes_host.sv
// Purpose: Host model shifting frames on the link
// Assumes: Link clock runs only inside frames
// Notes:   Same bit on both lane groups
`timescale 1ns/1ns
module fbes_host (
    output logic sclk,
    output logic cs_n,
    output logic lane_low_bit0,
    output logic lane_high_bit0
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        lane_low_bit0 = 1'b0;
        lane_high_bit0 = 1'b1;
    end
    // Caller sends unlock before each write
    task automatic send(input logic [47:0] d, input int n);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            lane_low_bit0 = d[47 - i];
            lane_high_bit0 = d[47 - i];
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1; // Right after last bit
        lane_low_bit0 = ~lane_low_bit0; // Released lanes must not hold
        lane_high_bit0 = ~lane_high_bit0;
        #200; // Gap lets the core clock see chip select rise before the next frame
    endtask
endmodule

// >>> flash_bulk_erase_suspend_ctrl_tb_top.sv
// Purpose: Self-checking bench for the erase controller
// Assumes: Host model on a 48 ns link clock
// Notes:   Erase counts shortened by parameters
`timescale 1ns/1ns
module flash_bulk_erase_suspend_ctrl_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk, cs_n, lo, hi, rdone, rer, rund;
    logic [15:0] lock = 16'h0000;
    logic [15:0] r = 16'hB06A;
    logic [15:0] emap;
    logic [7:0]  s1, s2, bank;
    logic [3:0]  rsec;
    logic [1:0]  notes[$];
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    always #10 clk = ~clk;
    fbes_host h (.sclk(sclk), .cs_n(cs_n), .lane_low_bit0(lo), .lane_high_bit0(hi));
    fbes_ctrl #(.BULK_ERASE_CYCLES(32'h50), .SECTOR_ERASE_CYCLES(32'h50), .PROGRAM_CYCLES(32'h30),
        .SUSPEND_LAT_CYCLES(32'h05)) dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .lane_low_bit0(lo), .lane_high_bit0(hi), .persistent_sector_lock(lock), .status_one(s1),
        .status_two(s2), .bank_reg(bank), .erased_map(emap), .read_sector(rsec), .read_done(rdone),
        .read_erased(rer), .read_undefined(rund));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic f(input logic [47:0] d, input int n);
        @(negedge clk);
        h.send(d, n);
    endtask
    task automatic c(input logic [7:0] op);
        f({op, 40'h0}, 8);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 300 && s1[0] !== 1'b0; i++) @(negedge clk);
    endtask
    task automatic conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(negedge clk) begin
        if (rdone === 1'b1) chk({14'h0, rund, rer}, {14'h0, notes.pop_front()});
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        r = lfsr(r);
        lock = r & 16'hFFDB; // Sectors 2 and 5 stay open for the suspend test
        repeat (10) @(negedge clk);
        rst = 1'b0;
        c(8'hC7);
        chk(16'(s1[0]), 16'h0);
        c(8'h06);
        f({8'hC7, 40'h0}, 9);
        chk(16'(s1[0]), 16'h0);
        c(8'h06);
        f({8'h01, 8'h04, 32'h0}, 16);
        c(8'h06);
        c(8'h60);
        chk(16'(s1[5:0]), 16'h0004);
        c(8'h06);
        f({8'h01, 40'h0}, 16);
        $display("bulk refusal tests done");
        c(8'h06);
        f({8'hD8, 24'h500000, 16'h0}, 32);
        chk(16'(s1[0]), 16'h1);
        c(8'h75);
        wait_idle();
        chk(16'(s2[1:0]), 16'h2);
        r = lfsr(r);
        notes.push_back(2'b10);
        f({8'h0B, 8'h5A, r, 16'h0}, 40);
        notes.push_back(2'b00);
        f({8'h0B, 24'h200000, 16'h0}, 40);
        chk(16'(rsec), 16'h2);
        c(8'h06);
        f({8'h02, 24'h500000, r[7:0], 8'h0}, 40);
        wait_idle();
        chk(16'({s1[6], s2[1]}), 16'h3);
        c(8'h06);
        f({8'h02, 24'h200000, r[7:0], 8'h0}, 40);
        chk(16'({s1[0], s2[1]}), 16'h3);
        c(8'h85);
        chk(16'({s1[0], s2[1:0]}), 16'h3);
        c(8'h8A);
        chk(16'(s1[0]), 16'h1);
        wait_idle();
        chk(16'({s1[0], s2[1:0]}), 16'h2);
        c(8'h06);
        f({8'h01, 8'h1C, 32'h0}, 16);
        chk(16'(s1[4:2]), 16'h0);
        c(8'hB9);
        f({8'h01, 8'h3C, 32'h0}, 16);
        chk(16'(bank), 16'h003C);
        c(8'h30);
        chk(16'(s1[6]), 16'h0);
        c(8'h7A);
        chk(16'({s1[0], s2[1]}), 16'h2);
        c(8'h7A);
        wait_idle();
        chk(16'(emap[5]), 16'h1);
        @(negedge clk);
        r = lfsr(r);
        lock = r & 16'hFFDB; // Fresh lock pattern for the bulk erase
        c(8'h06);
        c(8'h60);
        c(8'h75);
        chk(16'({s1[0], s2[1]}), 16'h2);
        wait_idle();
        chk(emap, ~lock);
        c(8'h7A);
        chk(16'(s1[0]), 16'h0);
        $display("suspend tests done");
        conclude();
    end
endmodule
